// [rtl/txm_pkg.sv]
// Shared constants and types for translation fault entry and instruction buffer access
package txm_pkg;

    // ***********************************************************
    // Array decode
    // ***********************************************************
    localparam logic [31:0] OFS_TAG     = 32'hF200_0000;
    localparam logic [31:0] OFS_D1      = 32'hF300_0000;
    localparam logic [31:0] OFS_D2      = 32'hF380_0000;
    localparam int          IDX_LO      = 8;
    localparam int          IDX_HI      = 9;
    localparam int          N_ENTRY     = 4;

    // ***********************************************************
    // Field layouts
    // ***********************************************************
    localparam int          VPN_LO      = 10;
    localparam int          PPN_LO      = 10;
    localparam int          PPN_HI      = 28;
    localparam int          V_POS       = 8;
    localparam int          SZH_POS     = 7;
    localparam int          PR_POS      = 6;
    localparam int          SZL_POS     = 4;
    localparam int          C_POS       = 3;
    localparam int          SH_POS      = 1;
    localparam int          TC_POS      = 3;
    localparam logic [31:0] MASK_TAG    = 32'hFFFF_FDFF;
    localparam logic [31:0] MASK_D1     = 32'h1FFF_FDDA;
    localparam logic [31:0] MASK_D2     = 32'h0000_000F;

    // ***********************************************************
    // Exception entry
    // ***********************************************************
    localparam logic [11:0] EXC_PROT_RD = 12'h0A0;
    localparam logic [11:0] EXC_PROT_WR = 12'h0C0;
    localparam logic [11:0] EXC_IPW     = 12'h080;
    localparam logic [31:0] VEC_OFS     = 32'h0000_0100;
    localparam int          MD_POS      = 30;
    localparam int          RB_POS      = 29;
    localparam int          BL_POS      = 28;
    localparam logic [2:0]  P2_TOP      = 3'h5;
    localparam logic [3:0]  SETTLE_CNT  = 4'h8;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [11:0] RST_CODE    = 12'h000;

    // Data access kinds seen by the translation check
    typedef enum logic [2:0] {
        OP_LOAD,
        OP_STORE,
        OP_PURGE,
        OP_WBACK,
        OP_INVAL,
        OP_ALLOC
    } txm_op_e;

endpackage

// [rtl/txm_if.sv]
// Interface joining the load/store pipeline and the translation fault block
interface txm_if;
    import txm_pkg::*;

    // Array access path
    logic                  acc_req;
    logic                  acc_we;
    logic                  acc_long;
    logic                  acc_fetch;
    logic [31:0]           acc_addr;
    logic [31:0]           acc_wdata;
    logic                  acc_ack;
    logic                  acc_err;
    logic [31:0]           acc_rdata;
    // Translation result and context
    logic                  xlt_valid;
    txm_op_e               xlt_op;
    logic                  xlt_hit;
    logic [1:0]            xlt_pr;
    logic                  xlt_dirty;
    logic [31:0]           xlt_vaddr;
    logic [31:0]           ctx_pc;
    logic                  ctx_slot;
    logic [31:0]           ctx_branch_pc;
    logic [31:0]           ctx_status;
    logic [31:0]           ctx_stack;
    logic [31:0]           ctx_vbr;
    // Exception entry answer
    logic                  exc_take;
    logic [31:0]           exc_vector;
    logic [31:0]           exc_status;

    modport dev (
        input  acc_req, acc_we, acc_long, acc_fetch, acc_addr, acc_wdata,
        input  xlt_valid, xlt_op, xlt_hit, xlt_pr, xlt_dirty, xlt_vaddr,
        input  ctx_pc, ctx_slot, ctx_branch_pc, ctx_status, ctx_stack, ctx_vbr,
        output acc_ack, acc_err, acc_rdata, exc_take, exc_vector, exc_status
    );
    modport pipe (
        output acc_req, acc_we, acc_long, acc_fetch, acc_addr, acc_wdata,
        output xlt_valid, xlt_op, xlt_hit, xlt_pr, xlt_dirty, xlt_vaddr,
        output ctx_pc, ctx_slot, ctx_branch_pc, ctx_status, ctx_stack, ctx_vbr,
        input  acc_ack, acc_err, acc_rdata, exc_take, exc_vector, exc_status
    );
endinterface

// [rtl/txm_entry_file.sv]
// Four-entry instruction translation buffer store with three array views
module txm_entry_file
    import txm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        we_tag_i,
    input  wire logic        we_d1_i,
    input  wire logic        we_d2_i,
    input  wire logic [1:0]  idx_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] tag_word_o,
    output logic      [31:0] d1_word_o,
    output logic      [31:0] d2_word_o
);
    import txm_pkg::*;

    logic [21:0] vpn_q  [N_ENTRY];
    logic [7:0]  space_id_q [N_ENTRY];
    logic [18:0] ppn_q  [N_ENTRY];
    logic [1:0]  sz_q   [N_ENTRY];
    logic [2:0]  sa_q   [N_ENTRY];
    logic        v_q    [N_ENTRY];
    logic        pr_q   [N_ENTRY];
    logic        c_q    [N_ENTRY];
    logic        sh_q   [N_ENTRY];
    logic        tc_q   [N_ENTRY];

    // ***********************************************************
    // Entry storage
    // ***********************************************************
    for (genvar e = 0; e < N_ENTRY; e++) begin : g_ent
        logic sel;
        assign sel = (idx_i == 2'(e));
        // One valid flop serves both views so they never disagree
        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                v_q[e] <= 1'b0;
            end else if (sel && (we_tag_i || we_d1_i)) begin
                v_q[e] <= wdata_i[V_POS];
            end
        end
        // Tag view fields; no reset needed, valid guards them
        always_ff @(posedge clk_i) begin
            if (sel && we_tag_i) begin
                vpn_q[e]  <= wdata_i[31:VPN_LO];
                space_id_q[e] <= wdata_i[7:0];
            end
        end
        // Data view one fields
        always_ff @(posedge clk_i) begin
            if (sel && we_d1_i) begin
                ppn_q[e] <= wdata_i[PPN_HI:PPN_LO];
                sz_q[e]  <= {wdata_i[SZH_POS], wdata_i[SZL_POS]};
                pr_q[e]  <= wdata_i[PR_POS];
                c_q[e]   <= wdata_i[C_POS];
                sh_q[e]  <= wdata_i[SH_POS];
            end
        end
        // Data view two fields
        always_ff @(posedge clk_i) begin
            if (sel && we_d2_i) begin
                sa_q[e] <= wdata_i[2:0];
                tc_q[e] <= wdata_i[TC_POS];
            end
        end
    end

    // ***********************************************************
    // Read views; reserved bits return zero
    // ***********************************************************
    assign tag_word_o = {vpn_q[idx_i], 1'b0, v_q[idx_i], space_id_q[idx_i]};
    assign d1_word_o  = {3'b000, ppn_q[idx_i], 1'b0, v_q[idx_i], sz_q[idx_i][1],
                         pr_q[idx_i], 1'b0, sz_q[idx_i][0], c_q[idx_i], 1'b0,
                         sh_q[idx_i], 1'b0};
    assign d2_word_o  = {28'h0000000, tc_q[idx_i], sa_q[idx_i]};
endmodule

// [rtl/txm_dev.sv]
// Device end: fault entry sequencing and memory-mapped instruction buffer arrays
module txm_dev
    import txm_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    txm_if.dev         bus,
    output logic [31:0] page_entry_high_o,
    output logic [31:0] fault_address_o,
    output logic [11:0] exception_event_o,
    output logic [31:0] saved_pc_o,
    output logic [31:0] saved_status_o,
    output logic [31:0] saved_stack_o
);
    import txm_pkg::*;

    logic        is_write;
    logic        allowed;
    logic        prot_fault;
    logic        ipw_fault;
    logic        take;
    logic        hit_tag;
    logic        hit_d1;
    logic        hit_d2;
    logic        legal;
    logic [1:0]  idx;
    logic [31:0] tag_word;
    logic [31:0] d1_word;
    logic [31:0] d2_word;
    logic [31:0] rd_mux;

    logic [31:0] page_entry_high_q;
    logic [31:0] fault_address_q;
    logic [11:0] exception_event_q;
    logic [31:0] saved_pc_q;
    logic [31:0] saved_status_q;
    logic [31:0] saved_stack_q;
    logic        exc_take_q;
    logic [31:0] exc_vector_q;
    logic [31:0] exc_status_q;
    logic        acc_ack_q;
    logic        acc_err_q;
    logic [31:0] acc_rdata_q;

    // ***********************************************************
    // Access classification
    // ***********************************************************
    // Cache purge and writeback only read the line; invalidate and
    // allocate-store overwrite it, so they are treated as writes
    always_comb begin
        unique case (bus.xlt_op)
            OP_STORE, OP_INVAL, OP_ALLOC: is_write = 1'b1;
            default:                      is_write = 1'b0;
        endcase
    end

    // Right field: high bit opens user mode, low bit opens writes
    always_comb begin
        if (bus.ctx_status[MD_POS]) begin
            allowed = !is_write || bus.xlt_pr[0];
        end else begin
            allowed = bus.xlt_pr[1] && (!is_write || bus.xlt_pr[0]);
        end
    end

    assign prot_fault = bus.xlt_hit && !allowed;
    assign ipw_fault  = bus.xlt_hit && allowed && is_write && !bus.xlt_dirty;
    assign take       = bus.xlt_valid && (prot_fault || ipw_fault);

    // ***********************************************************
    // Fault context capture
    // ***********************************************************
    // Faulting page and address
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            page_entry_high_q <= RST_WORD;
            fault_address_q   <= RST_WORD;
        end else if (take) begin
            page_entry_high_q <= {bus.xlt_vaddr[31:VPN_LO], page_entry_high_q[VPN_LO-1:0]};
            fault_address_q   <= bus.xlt_vaddr;
        end
    end

    // Exception code; protection fault wins over a clean-page write
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            exception_event_q <= RST_CODE;
        end else if (take) begin
            if (prot_fault) begin
                exception_event_q <= is_write ? EXC_PROT_WR : EXC_PROT_RD;
            end else begin
                exception_event_q <= EXC_IPW;
            end
        end
    end

    // Return point: a slot instruction restarts at its branch
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            saved_pc_q <= RST_WORD;
        end else if (take) begin
            saved_pc_q <= bus.ctx_slot ? bus.ctx_branch_pc : bus.ctx_pc;
        end
    end

    // Status and stack pointer as they stood before entry
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            saved_status_q <= RST_WORD;
            saved_stack_q  <= RST_WORD;
        end else if (take) begin
            saved_status_q <= bus.ctx_status;
            saved_stack_q  <= bus.ctx_stack;
        end
    end

    // ***********************************************************
    // Vectoring
    // ***********************************************************
    // The pipeline loads the new status and fetch address on the pulse
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            exc_take_q   <= 1'b0;
            exc_vector_q <= RST_WORD;
            exc_status_q <= RST_WORD;
        end else begin
            exc_take_q <= take;
            if (take) begin
                exc_vector_q <= bus.ctx_vbr + VEC_OFS;
                exc_status_q <= bus.ctx_status | (32'h1 << MD_POS) | (32'h1 << BL_POS)
                                | (32'h1 << RB_POS);
            end
        end
    end

    // ***********************************************************
    // Array decode
    // ***********************************************************
    assign hit_tag = (bus.acc_addr[31:24] == OFS_TAG[31:24]);
    assign hit_d1  = (bus.acc_addr[31:23] == OFS_D1[31:23]);
    assign hit_d2  = (bus.acc_addr[31:23] == OFS_D2[31:23]);
    assign idx     = bus.acc_addr[IDX_HI:IDX_LO];
    // Only longword data moves reach the arrays
    assign legal   = bus.acc_req && bus.acc_long && !bus.acc_fetch
                     && (hit_tag || hit_d1 || hit_d2);

    txm_entry_file u_entries (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .we_tag_i   (legal && bus.acc_we && hit_tag),
        .we_d1_i    (legal && bus.acc_we && hit_d1),
        .we_d2_i    (legal && bus.acc_we && hit_d2),
        .idx_i      (idx),
        .wdata_i    (bus.acc_wdata),
        .tag_word_o (tag_word),
        .d1_word_o  (d1_word),
        .d2_word_o  (d2_word)
    );

    // Reserved bits are returned as zero, which software may not rely on
    always_comb begin
        if (hit_tag) begin
            rd_mux = tag_word;
        end else if (hit_d1) begin
            rd_mux = d1_word;
        end else if (hit_d2) begin
            rd_mux = d2_word;
        end else begin
            rd_mux = RST_WORD;
        end
    end

    // One-cycle answer; refused accesses get an error and no data
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            acc_ack_q   <= 1'b0;
            acc_err_q   <= 1'b0;
            acc_rdata_q <= RST_WORD;
        end else begin
            acc_ack_q <= bus.acc_req;
            acc_err_q <= bus.acc_req && !legal;
            if (legal && !bus.acc_we) begin
                acc_rdata_q <= rd_mux;
            end
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign bus.acc_ack        = acc_ack_q;
    assign bus.acc_err        = acc_err_q;
    assign bus.acc_rdata      = acc_rdata_q;
    assign bus.exc_take       = exc_take_q;
    assign bus.exc_vector     = exc_vector_q;
    assign bus.exc_status     = exc_status_q;
    assign page_entry_high_o  = page_entry_high_q;
    assign fault_address_o    = fault_address_q;
    assign exception_event_o  = exception_event_q;
    assign saved_pc_o         = saved_pc_q;
    assign saved_status_o     = saved_status_q;
    assign saved_stack_o      = saved_stack_q;
endmodule

// [rtl/txm_pipe.sv]
// Pipeline end: issues array moves under its obligations and forwards fault context
module txm_pipe
    import txm_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    txm_if.pipe                bus,
    input  wire logic          core_acc_req_i,
    input  wire logic          core_acc_we_i,
    input  wire logic [31:0]   core_acc_addr_i,
    input  wire logic [31:0]   core_acc_wdata_i,
    input  wire logic          core_priv_i,
    input  wire logic [31:0]   core_pc_i,
    input  wire logic          core_retire_i,
    input  wire logic          core_xlt_valid_i,
    input  wire txm_op_e       core_xlt_op_i,
    input  wire logic          core_xlt_hit_i,
    input  wire logic [1:0]    core_xlt_pr_i,
    input  wire logic          core_xlt_dirty_i,
    input  wire logic [31:0]   core_xlt_vaddr_i,
    input  wire logic          core_slot_i,
    input  wire logic [31:0]   core_branch_pc_i,
    input  wire logic [31:0]   core_status_i,
    input  wire logic [31:0]   core_stack_i,
    input  wire logic [31:0]   core_vbr_i,
    output logic               core_acc_refused_o,
    output logic               core_acc_done_o,
    output logic [31:0]        core_acc_rdata_o,
    output logic               core_branch_hold_o,
    output logic               core_redirect_o,
    output logic [31:0]        core_redirect_pc_o,
    output logic [31:0]        core_new_status_o
);
    import txm_pkg::*;

    logic        may_issue;
    logic        issue;
    logic        busy_q;
    logic [3:0]  settle_q;
    logic [31:0] wmask;

    // ***********************************************************
    // Array move issue
    // ***********************************************************
    // Moves leave only from privileged code in the uncached region
    assign may_issue = core_priv_i && (core_pc_i[31:29] == P2_TOP);
    assign issue     = core_acc_req_i && may_issue && !busy_q;

    // Reserved bits are cleared so stray data never lands in them
    always_comb begin
        if (core_acc_addr_i[31:24] == OFS_TAG[31:24]) begin
            wmask = MASK_TAG;
        end else if (core_acc_addr_i[31:23] == OFS_D1[31:23]) begin
            wmask = MASK_D1;
        end else begin
            wmask = MASK_D2;
        end
    end

    assign bus.acc_req   = issue;
    assign bus.acc_we    = core_acc_we_i;
    assign bus.acc_long  = 1'b1;
    assign bus.acc_fetch = 1'b0;
    assign bus.acc_addr  = {core_acc_addr_i[31:2], 2'b00};
    assign bus.acc_wdata = core_acc_wdata_i & wmask;

    // One move outstanding; the answer frees the slot
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            busy_q <= 1'b0;
        end else if (issue) begin
            busy_q <= 1'b1;
        end else if (bus.acc_ack) begin
            busy_q <= 1'b0;
        end
    end

    // Retired instructions after a move before leaving the region
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            settle_q <= 4'h0;
        end else if (issue) begin
            settle_q <= SETTLE_CNT;
        end else if (core_retire_i && settle_q != 4'h0) begin
            settle_q <= settle_q - 4'h1;
        end
    end

    assign core_branch_hold_o = (settle_q != 4'h0);
    assign core_acc_refused_o = core_acc_req_i && !may_issue;
    assign core_acc_done_o    = bus.acc_ack;
    assign core_acc_rdata_o   = bus.acc_rdata;

    // ***********************************************************
    // Translation result and context forwarding
    // ***********************************************************
    assign bus.xlt_valid     = core_xlt_valid_i;
    assign bus.xlt_op        = core_xlt_op_i;
    assign bus.xlt_hit       = core_xlt_hit_i;
    assign bus.xlt_pr        = core_xlt_pr_i;
    assign bus.xlt_dirty     = core_xlt_dirty_i;
    assign bus.xlt_vaddr     = core_xlt_vaddr_i;
    assign bus.ctx_pc        = core_pc_i;
    assign bus.ctx_slot      = core_slot_i;
    assign bus.ctx_branch_pc = core_branch_pc_i;
    assign bus.ctx_status    = core_status_i;
    assign bus.ctx_stack     = core_stack_i;
    assign bus.ctx_vbr       = core_vbr_i;
    assign core_redirect_o    = bus.exc_take;
    assign core_redirect_pc_o = bus.exc_vector;
    assign core_new_status_o  = bus.exc_status;
endmodule

// [test/txm_chk_sva.sv]
// Concurrent checks on the array path and fault entry of the block interface
module txm_chk
    import txm_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        acc_req,
    input wire logic        acc_we,
    input wire logic        acc_long,
    input wire logic        acc_fetch,
    input wire logic [31:0] acc_addr,
    input wire logic        acc_ack,
    input wire logic        acc_err,
    input wire logic [31:0] acc_rdata,
    input wire logic        xlt_valid,
    input wire txm_op_e     xlt_op,
    input wire logic        xlt_hit,
    input wire logic [1:0]  xlt_pr,
    input wire logic        xlt_dirty,
    input wire logic [31:0] ctx_status,
    input wire logic [31:0] ctx_vbr,
    input wire logic        exc_take,
    input wire logic [31:0] exc_vector,
    input wire logic [31:0] exc_status
);
    // ****************
    // Decode helpers
    // ****************
    logic legal;
    logic wr_op;
    logic fault;
    // Only longword data moves into the three windows are answered cleanly
    assign legal = acc_long && !acc_fetch && (acc_addr[31:24] == 8'hF2
                   || acc_addr[31:23] == 9'h1E6 || acc_addr[31:23] == 9'h1E7);
    assign wr_op = xlt_op inside {OP_STORE, OP_INVAL, OP_ALLOC};
    // Clean-page writes share the entry path, so one flag covers both faults
    assign fault = xlt_hit && ((!ctx_status[MD_POS] && !xlt_pr[1])
                   || (wr_op && (!xlt_pr[0] || !xlt_dirty)));
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_fault;
        xlt_valid && fault;
    endsequence
    sequence s_d2_read;
        acc_req && !acc_we && legal && acc_addr[31:23] == 9'h1E7;
    endsequence
    a_ack_next: assert property (acc_req |=> acc_ack)
        else $error("move not acknowledged");
    a_ack_quiet: assert property (!acc_req |=> !acc_ack)
        else $error("ack without move");
    a_err_illegal: assert property (acc_req && !legal |=> acc_ack && acc_err)
        else $error("illegal move not refused");
    a_legal_clean: assert property (acc_req && legal |=> !acc_err)
        else $error("legal move refused");
    a_fault_vector: assert property (s_fault |=> exc_take
        && exc_vector == $past(ctx_vbr) + VEC_OFS)
        else $error("bad fault vector");
    a_fault_status: assert property (s_fault |=> exc_status
        == ($past(ctx_status) | 32'h7000_0000))
        else $error("bad entry status");
    a_take_quiet: assert property (!(xlt_valid && fault) |=> !exc_take)
        else $error("entry without fault");
    a_d2_reserved: assert property (s_d2_read |=> acc_rdata[31:4] == 28'h0)
        else $error("data two reserved bits set");
endmodule

// [test/tb_top.sv]
// Bench joining both ends, with a rule-breaking driver on a second device
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import txm_pkg::*;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        req, we, priv, ret, xv, hit, dty, slot, refd, done, hold, redir;
    logic [1:0]  pr;
    logic [11:0] code, ec;
    logic [31:0] addr, wd, pc, va, bpc, st, sp, vector_base_reg, rd, rpc, nst;
    logic [31:0] ph, fa, saved_pc_reg, sst, ssk, t, d1, d2;
    txm_op_e     op;
    int          errors = 0;
    int          num_checks = 0;
    txm_if bus();
    txm_if bus2();
    txm_dev txm_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .page_entry_high_o(ph),
        .fault_address_o(fa), .exception_event_o(code), .saved_pc_o(saved_pc_reg),
        .saved_status_o(sst), .saved_stack_o(ssk));
    txm_dev txm_dev_i2 (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus2), .page_entry_high_o(),
        .fault_address_o(), .exception_event_o(), .saved_pc_o(), .saved_status_o(),
        .saved_stack_o());
    txm_pipe txm_pipe_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .core_acc_req_i(req),
        .core_acc_we_i(we), .core_acc_addr_i(addr), .core_acc_wdata_i(wd), .core_priv_i(priv),
        .core_pc_i(pc), .core_retire_i(ret), .core_xlt_valid_i(xv), .core_xlt_op_i(op),
        .core_xlt_hit_i(hit), .core_xlt_pr_i(pr), .core_xlt_dirty_i(dty), .core_xlt_vaddr_i(va),
        .core_slot_i(slot), .core_branch_pc_i(bpc), .core_status_i(st), .core_stack_i(sp),
        .core_vbr_i(vector_base_reg), .core_acc_refused_o(refd), .core_acc_done_o(done),
        .core_acc_rdata_o(rd), .core_branch_hold_o(hold), .core_redirect_o(redir),
        .core_redirect_pc_o(rpc), .core_new_status_o(nst));
    txm_chk txm_chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .acc_req(bus.acc_req),
        .acc_we(bus.acc_we), .acc_long(bus.acc_long), .acc_fetch(bus.acc_fetch),
        .acc_addr(bus.acc_addr), .acc_ack(bus.acc_ack), .acc_err(bus.acc_err),
        .acc_rdata(bus.acc_rdata), .xlt_valid(bus.xlt_valid), .xlt_op(bus.xlt_op),
        .xlt_hit(bus.xlt_hit), .xlt_pr(bus.xlt_pr), .xlt_dirty(bus.xlt_dirty),
        .ctx_status(bus.ctx_status), .ctx_vbr(bus.ctx_vbr), .exc_take(bus.exc_take),
        .exc_vector(bus.exc_vector), .exc_status(bus.exc_status));
    // Second device only sees array moves, so its lookup side stays idle
    assign bus2.xlt_valid = 1'b0;
    assign bus2.xlt_op = OP_LOAD;
    assign {bus2.xlt_hit, bus2.xlt_pr, bus2.xlt_dirty, bus2.xlt_vaddr, bus2.ctx_pc, bus2.ctx_slot,
        bus2.ctx_branch_pc, bus2.ctx_status, bus2.ctx_stack, bus2.ctx_vbr} = '0;
    // Core clock
    always #50 clk_i = ~clk_i;
    task automatic chk(logic [31:0] g, logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Expected event code, zero when no entry is due
    function automatic logic [11:0] exp_code(txm_op_e o, logic [1:0] p, logic d, logic u, logic h);
        logic w;
        w = o inside {OP_STORE, OP_INVAL, OP_ALLOC};
        if (h && ((u && !p[1]) || (w && !p[0])))
            return w ? EXC_PROT_WR : EXC_PROT_RD;
        return (h && w && !d) ? EXC_IPW : 12'h000;
    endfunction
    // One move; an idle edge first keeps the request from being set twice in a step
    task automatic mv(logic w, logic [31:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        we = w;
        addr = a;
        wd = d;
        req = 1'b1;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        req = 1'b0;
        if (n == 20) begin
            errors++;
            $display("ERROR %0t: move not answered", $time);
        end
    endtask
    initial begin
        #(100 * 20000);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {req, we, xv, hit, dty, slot, pr} = '0;
        {priv, ret} = 2'h3;
        {addr, wd, va, bpc, st, sp, vector_base_reg} = '0;
        pc = 32'hA000_0100;
        op = OP_LOAD;
        {bus2.acc_req, bus2.acc_we, bus2.acc_long, bus2.acc_fetch} = '0;
        {bus2.acc_addr, bus2.acc_wdata} = '0;
        void'($urandom(32'h9EB3));
        repeat (8) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        // Every entry through all three views; valid is shared, so data one wins
        for (int i = 0; i < N_ENTRY; i++) begin
            t = $urandom & MASK_TAG;
            d1 = $urandom & MASK_D1;
            d2 = $urandom & MASK_D2;
            mv(1'b1, OFS_TAG | (i << IDX_LO), t);
            mv(1'b1, OFS_D1 | (i << IDX_LO), d1);
            mv(1'b1, OFS_D2 | (i << IDX_LO), d2);
            mv(1'b0, OFS_TAG | (i << IDX_LO), 32'h0);
            chk(rd, {t[31:9], d1[8], t[7:0]});
            mv(1'b0, OFS_D1 | (i << IDX_LO), 32'h0);
            chk(rd, d1);
            mv(1'b0, OFS_D2 | (i << IDX_LO), 32'h0);
            chk(rd, d2);
        end
        // Unmapped move is refused and leaves the last read word standing
        mv(1'b0, 32'hF400_0000, 32'h0);
        chk(rd, d2);
        repeat (7) @(posedge clk_i);
        #1 chk(hold, 32'h1);
        @(posedge clk_i);
        #1 chk(hold, 32'h0);
        // User code, then privileged code outside the region, are both turned away
        #1 req = 1'b1;
        priv = 1'b0;
        #1 chk(refd, 32'h1);
        priv = 1'b1;
        pc = 32'h8000_0000;
        #1 chk(refd, 32'h1);
        @(posedge clk_i);
        #1 req = 1'b0;
        chk(done, 32'h0);
        // Lookups over every access kind, right and mode
        for (int k = 0; k < 48; k++) begin
            op = txm_op_e'(k % 6);
            {pr, dty, slot, hit} = $urandom;
            {st, va, pc} = {$urandom, $urandom, $urandom};
            {bpc, sp, vector_base_reg} = {$urandom, $urandom, $urandom};
            xv = 1'b1;
            ec = exp_code(op, pr, dty, !st[MD_POS], hit);
            @(posedge clk_i);
            #1 xv = 1'b0;
            chk(redir, ec != 12'h000);
            if (ec != 12'h000) begin
                chk(code, ec);
                chk(rpc, vector_base_reg + VEC_OFS);
                chk(nst, st | 32'h7000_0000);
                chk(saved_pc_reg, slot ? bpc : pc);
                chk(sst, st);
                chk(ssk, sp);
                chk(fa, va);
                chk(ph[31:10], va[31:10]);
            end
            @(posedge clk_i);
            #1;
        end
        // Second device: short word, fetch, unmapped, then one legal longword
        for (int j = 0; j < 4; j++) begin
            #1 bus2.acc_long = (j != 0);
            bus2.acc_fetch = (j == 1);
            bus2.acc_addr = (j == 2) ? 32'hF400_0000 : OFS_D2;
            bus2.acc_we = 1'b1;
            bus2.acc_req = 1'b1;
            @(posedge clk_i);
            #1 bus2.acc_req = 1'b0;
            chk({bus2.acc_ack, bus2.acc_err}, {1'b1, j != 3});
            @(posedge clk_i);
        end
        tally_and_finish();
    end
endmodule
